/* bench/runaway_code_watchdog_tb.sv */
// Self-checking bench for the runaway code watchdog
`timescale 1ns/1ps
`default_nettype none
module runaway_code_watchdog_tb
  import wdog_pkg::*;
;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [ADDR_W-1:0] paddr_i = '0;
  logic [31:0] pwdata_i = '0, prdata_o, rd;
  logic [7:0] reset_vector_low_i = 8'h5a;
  logic monitor_mode_i = 1'b0, break_state_i = 1'b0, stop_mode_i = 1'b0, stop_instr_i = 1'b0;
  logic internal_reset_i = 1'b0, vector_fetch_i = 1'b0;
  logic hv_on_reset_pin_i = 1'b0, hv_on_irq_pin_one_i = 1'b0;
  logic pready_o, pslverr_o, reset_pin_o, reset_pin_oe_n_o, timeout_reset_o, err;
  logic watchdog_cause_flag_o, watchdog_disable_o, irq_o;
  wire logic reset_pin_i;
  int num_errors = 0, n_compared = 0, cyc = 0, pulls = 0;

  // Open-drain pin with a pull-up: high whenever the block lets go of it
  assign reset_pin_i = reset_pin_oe_n_o ? 1'b1 : reset_pin_o;

  runaway_code_watchdog uut (
    .sys_clk_i             (sys_clk_i),
    .rst_n_i               (rst_n_i),
    .psel_i                (psel_i),
    .penable_i             (penable_i),
    .pwrite_i              (pwrite_i),
    .paddr_i               (paddr_i),
    .pwdata_i              (pwdata_i),
    .prdata_o              (prdata_o),
    .pready_o              (pready_o),
    .pslverr_o             (pslverr_o),
    .reset_vector_low_i    (reset_vector_low_i),
    .monitor_mode_i        (monitor_mode_i),
    .break_state_i         (break_state_i),
    .stop_mode_i           (stop_mode_i),
    .stop_instr_i          (stop_instr_i),
    .internal_reset_i      (internal_reset_i),
    .vector_fetch_i        (vector_fetch_i),
    .hv_on_reset_pin_i     (hv_on_reset_pin_i),
    .hv_on_irq_pin_one_i   (hv_on_irq_pin_one_i),
    .reset_pin_i           (reset_pin_i),
    .reset_pin_o           (reset_pin_o),
    .reset_pin_oe_n_o      (reset_pin_oe_n_o),
    .timeout_reset_o       (timeout_reset_o),
    .watchdog_cause_flag_o (watchdog_cause_flag_o),
    .watchdog_disable_o    (watchdog_disable_o),
    .irq_o                 (irq_o)
  );

  always #2.5 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (reset_pin_oe_n_o === 1'b0) pulls <= pulls + 1;
    if (cyc == 60000) begin
      num_errors++;
      finish_test();
    end
  end

  task finish_test;
    $display("errors %0d, compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  // One zero-wait transfer; the idle edge after it lets the design's updates land
  task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : apb

  task t_regs;
    apb(1'b0, 18'h3fffc, 32'h0);
    chk(rd, {24'h0, reset_vector_low_i}, "service read");
    apb(1'b0, 18'h00004, 32'h0);
    chk(rd, 32'h100, "status after reset");
    apb(1'b1, 18'h00000, 32'h3);
    apb(1'b0, 18'h00000, 32'h0);
    chk(rd, 32'h3, "control readback");
    chk(watchdog_disable_o, 1'b1, "disable output");
    apb(1'b1, 18'h00000, 32'h0);
    apb(1'b0, 18'h00010, 32'h0);
    chk(rd, 32'h0, "unmapped read data");
    chk({31'h0, err}, 32'h1, "unmapped read error");
    $display("register test done");
  endtask : t_regs

  // Stop mode, monitor with test voltage and break with reset-pin test voltage freeze the count; break with irq-pin voltage does not
  task t_block;
    logic [4:0] tbl [5];
    logic [31:0] a;
    tbl = '{5'b10000, 5'b01010, 5'b01001, 5'b00110, 5'b00101};
    for (int i = 0; i < 5; i++) begin
      {stop_mode_i, monitor_mode_i, break_state_i, hv_on_reset_pin_i, hv_on_irq_pin_one_i} <= tbl[i];
      repeat (6) @(posedge sys_clk_i);
      apb(1'b0, 18'h0000c, 32'h0);
      a = rd;
      repeat (20) @(posedge sys_clk_i);
      apb(1'b0, 18'h0000c, 32'h0);
      chk(rd == a, i < 4, "count freeze");
      {stop_mode_i, monitor_mode_i, break_state_i, hv_on_reset_pin_i, hv_on_irq_pin_one_i} <= 5'h0;
      repeat (6) @(posedge sys_clk_i);
    end
    $display("block test done");
  endtask : t_block

  task t_clear;
    for (int i = 0; i < 3; i++) begin
      repeat (50) @(posedge sys_clk_i);
      // Stop instruction only ever pulsed on purpose, never stray
      {internal_reset_i, vector_fetch_i, stop_instr_i} <= 3'b100 >> i;
      @(posedge sys_clk_i);
      {internal_reset_i, vector_fetch_i, stop_instr_i} <= 3'b000;
      apb(1'b0, 18'h0000c, 32'h0);
      chk(rd[11:0] < 12'h008, 1'b1, "prescaler clear");
      if (i == 0) chk(rd[17:12], 6'h00, "counter clear");
    end
    $display("clear test done");
  endtask : t_clear

  // Power-on clear lands POR_CYC edges after the synchronised release at edge 7
  task t_por;
    while (cyc < POR_CYC + 8) @(posedge sys_clk_i);
    apb(1'b0, 18'h0000c, 32'h0);
    chk(rd[11:0] < 12'h008, 1'b1, "power-on prescaler clear");
    $display("power-on test done");
  endtask : t_por

  task t_timeout;
    int n;
    internal_reset_i <= 1'b1;
    @(posedge sys_clk_i);
    internal_reset_i <= 1'b0;
    n = 0;
    while (reset_pin_oe_n_o !== 1'b0 && n < 9000) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk(n >= 8170 && n <= 8184, 1'b1, "timeout length");
    n = 0;
    while (reset_pin_oe_n_o === 1'b0 && n < 40) begin
      @(posedge sys_clk_i);
      n++;
    end
    chk(n, 32, "pull length");
    chk(watchdog_cause_flag_o, 1'b1, "cause flag");
    apb(1'b1, 18'h00008, 32'h1);
    chk(irq_o, 1'b1, "irq unmasked");
    apb(1'b1, 18'h00008, 32'h0);
    chk(irq_o, 1'b0, "irq masked");
    apb(1'b1, 18'h00008, 32'h1);
    apb(1'b1, 18'h00004, 32'h1);
    chk({watchdog_cause_flag_o, irq_o}, 2'b00, "cause clear");
    apb(1'b1, 18'h00008, 32'h0);
    $display("timeout test done");
  endtask : t_timeout

  // Serviced every 4000 cycles, well inside the short period
  task t_service;
    int p0;
    p0 = pulls;
    repeat (3) begin
      repeat (4000) @(posedge sys_clk_i);
      apb(1'b1, 18'h3fffc, 32'hffffffff);
    end
    chk(pulls == p0, 1'b1, "serviced no reset");
    $display("service test done");
  endtask : t_service

  task t_disable;
    int p0;
    apb(1'b1, 18'h00000, 32'h2);
    p0 = pulls;
    repeat (9000) @(posedge sys_clk_i);
    chk(pulls == p0, 1'b1, "disabled no reset");
    apb(1'b1, 18'h00000, 32'h0);
    $display("disable test done");
  endtask : t_disable

  initial begin
    repeat (5) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    t_regs();
    t_block();
    t_clear();
    t_por();
    t_timeout();
    t_service();
    t_disable();
    finish_test();
  end
endmodule : runaway_code_watchdog_tb
`default_nettype wire

/* bench/wdog_properties.sv */
// Assertion checker for the runaway code watchdog
`timescale 1ns/1ps
`default_nettype none
module wdog_properties
  import wdog_pkg::*;
(
  // Clock, reset and bus
  input wire logic              sys_clk_i,
  input wire logic              rst_n_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic [31:0]       prdata_o,
  input wire logic              pready_o,
  input wire logic              pslverr_o,
  // Watchdog side
  input wire logic [7:0]        reset_vector_low_i,
  input wire logic              reset_pin_o,
  input wire logic              reset_pin_oe_n_o,
  input wire logic              timeout_reset_o,
  input wire logic              watchdog_cause_flag_o,
  input wire logic              watchdog_disable_o
);
  logic [5:0] low_n;

  // Counts low cycles of the pin; wraps if stuck, which the bound catches
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) low_n <= 6'h00;
    else if (reset_pin_oe_n_o) low_n <= 6'h00;
    else low_n <= low_n + 6'h01;
  end

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence pull_start; $fell(reset_pin_oe_n_o); endsequence
  sequence pull_end; $rose(reset_pin_oe_n_o); endsequence
  sequence svc_rd; psel_i && !penable_i && !pwrite_i && paddr_i == 18'h3fffc; endsequence
  sequence ctl_wr; psel_i && penable_i && pwrite_i && paddr_i == 18'h00000; endsequence

  AST_PULL_LEN: assert property (pull_end |-> low_n == 6'h20)
    else $error("reset pull length wrong");
  AST_PULL_MAX: assert property (low_n <= 6'h20)
    else $error("reset pull too long");
  AST_PULL_CAUSE: assert property (pull_start |-> watchdog_cause_flag_o)
    else $error("cause flag missing at pull");
  AST_PULL_REQ: assert property (timeout_reset_o == !reset_pin_oe_n_o)
    else $error("reset request and pin differ");
  AST_PIN_ZERO: assert property (!reset_pin_o)
    else $error("reset pin drives high");
  AST_SVC_READ: assert property (svc_rd |=> prdata_o == {24'h000000, $past(reset_vector_low_i)})
    else $error("service read not vector byte");
  AST_DIS_FOLLOW: assert property (ctl_wr |=> watchdog_disable_o == $past(pwdata_i[1]))
    else $error("disable output not following bit");
  AST_DIS_NOPULL: assert property (watchdog_disable_o [*2] ##0 reset_pin_oe_n_o |=> reset_pin_oe_n_o)
    else $error("pull while disabled");
  AST_READY: assert property (psel_i && penable_i |-> pready_o)
    else $error("bus not ready");
  AST_UNMAPPED: assert property (psel_i && penable_i && paddr_i == 18'h00010 |-> pslverr_o)
    else $error("unmapped access accepted");
endmodule : wdog_properties

bind runaway_code_watchdog wdog_properties chk (
  .sys_clk_i             (sys_clk_i),
  .rst_n_i               (rst_n_i),
  .psel_i                (psel_i),
  .penable_i             (penable_i),
  .pwrite_i              (pwrite_i),
  .paddr_i               (paddr_i),
  .pwdata_i              (pwdata_i),
  .prdata_o              (prdata_o),
  .pready_o              (pready_o),
  .pslverr_o             (pslverr_o),
  .reset_vector_low_i    (reset_vector_low_i),
  .reset_pin_o           (reset_pin_o),
  .reset_pin_oe_n_o      (reset_pin_oe_n_o),
  .timeout_reset_o       (timeout_reset_o),
  .watchdog_cause_flag_o (watchdog_cause_flag_o),
  .watchdog_disable_o    (watchdog_disable_o)
);
`default_nettype wire

/* verilog/runaway_code_watchdog.sv */
// Runaway code watchdog with APB registers and reset pin driver
//
// How it works
// - A 12-bit prescaler on the oscillator clock feeds a free-running 6-bit counter.
// - Unserviced, it times out after 2^13-16 or 2^18-16 cycles by rate select.
// - Any write to the service register clears counter and prescaler stages 5..12.
// - Service register shares the reset vector address; reads give the vector low byte.
// - Timeout pulls the reset pin low 32 cycles and sets the cause flag.
// - In monitor mode, test voltage on reset or interrupt pin disables it.
// - During break, test voltage on the reset pin disables it.
// - Stop mode halts its clock; the stop instruction clears the prescaler.
// - Power-on logic clears the prescaler 4096 cycles after power-up.
// - Any internal reset clears both prescaler and counter.
// - A reset vector fetch clears the prescaler.
// - The disable output follows the disable bit; set means no timeout reset.
// - It keeps counting in wait mode and can still reset there.
// - Its timeout pulls the reset pin, sets the cause flag and, when that bit is unmasked, raises irq_o.
`timescale 1ns/1ps
`default_nettype none
module runaway_code_watchdog
  import wdog_pkg::*;
#(
  parameter int PRE_BITS = PRE_W,
  parameter int CNT_BITS = CNT_W
) (
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // APB slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic      [31:0]       prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // Chip mode and reset logic, same clock
  input  wire logic [7:0]        reset_vector_low_i,
  input  wire logic              monitor_mode_i,
  input  wire logic              break_state_i,
  input  wire logic              stop_mode_i,
  input  wire logic              stop_instr_i,
  input  wire logic              internal_reset_i,
  input  wire logic              vector_fetch_i,
  // Test voltage detectors, asynchronous
  input  wire logic              hv_on_reset_pin_i,
  input  wire logic              hv_on_irq_pin_one_i,
  // External reset pin, open drain
  input  wire logic              reset_pin_i,
  output logic                   reset_pin_o,
  output logic                   reset_pin_oe_n_o,
  // Reset request and status to system logic
  output logic                   timeout_reset_o,
  output logic                   watchdog_cause_flag_o,
  output logic                   watchdog_disable_o,
  output logic                   irq_o
);

  // Taps and compare constants are sized for the fixed geometry only
  if (PRE_BITS != PRE_W || CNT_BITS != CNT_W) begin : g_bad_geometry
    $error("watchdog geometry is fixed at 12-bit prescaler and 6-bit counter");
  end

  typedef enum logic [0:0] {
    ST_COUNT = 1'b0,
    ST_PULL  = 1'b1
  } wd_state_t;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
    addr_hit = (a == {idx, 2'b00});
  endfunction : addr_hit

  localparam logic [5:0]  PULL_LAST = 6'(PULL_CYC - 1);
  localparam logic [12:0] POR_LAST  = 13'(POR_CYC - 1);
  localparam logic [12:0] SHORT_END = 13'(SHORT_CYC - 1);
  localparam logic [17:0] LONG_END  = 18'(LONG_CYC - 1);

  // Reset release through two flops
  logic rst_meta_r;
  logic rst_sync_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // Pin-level inputs
  logic [2:0] pins_s;
  logic       hv_rst_s;
  logic       hv_irq_s;
  logic       rst_pin_s;

  wdog_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk_i   (sys_clk_i),
    .rst_n_i (rst_sync_r),
    .d_i     ({hv_on_reset_pin_i, hv_on_irq_pin_one_i, reset_pin_i}),
    .q_o     (pins_s)
  );

  assign hv_rst_s  = pins_s[2];
  assign hv_irq_s  = pins_s[1];
  assign rst_pin_s = pins_s[0];

  // APB decode; zero wait states
  logic apb_acc;
  logic wr_en;
  logic rd_en;
  logic hit_svc;
  logic hit_ctl;
  logic hit_st;
  logic hit_msk;
  logic hit_cnt;
  logic mapped;

  assign apb_acc = psel_i & penable_i;
  assign wr_en   = apb_acc & pwrite_i;
  assign rd_en   = apb_acc & ~pwrite_i;
  assign hit_svc = addr_hit(paddr_i, IDX_SERVICE);
  assign hit_ctl = addr_hit(paddr_i, IDX_CONTROL);
  assign hit_st  = addr_hit(paddr_i, IDX_STATUS);
  assign hit_msk = addr_hit(paddr_i, IDX_MASK);
  assign hit_cnt = addr_hit(paddr_i, IDX_COUNT);
  assign mapped  = hit_svc | hit_ctl | hit_st | hit_msk | hit_cnt;

  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc & ~mapped;

  // Configuration
  logic [1:0] ctl_r;
  logic       rate_long;
  logic       dis_cfg;

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      ctl_r <= CTL_RESET;
    end else if (wr_en && hit_ctl) begin
      ctl_r <= pwdata_i[1:0];
    end
  end

  assign rate_long          = ctl_r[CTL_RATE_BIT];
  assign dis_cfg            = ctl_r[CTL_DIS_BIT];
  assign watchdog_disable_o = dis_cfg;

  // Service write: the written value itself is ignored
  logic service;

  assign service = wr_en & hit_svc;

  // Power-on prescaler clear
  logic [12:0] por_cnt_r;
  logic        por_done_r;
  logic        por_clear;

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      por_cnt_r  <= '0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r <= por_cnt_r + 13'h0001;
      if (por_cnt_r == POR_LAST) begin
        por_done_r <= 1'b1;
      end
    end
  end

  assign por_clear = !por_done_r && (por_cnt_r == POR_LAST);

  // Enable conditions
  logic hv_block;
  logic running;
  logic pre_clear;
  wd_state_t state_r;

  // Test voltage disables counting, not just the reset, so no timeout is armed
  assign hv_block = (monitor_mode_i && (hv_rst_s || hv_irq_s))
                  || (break_state_i && hv_rst_s);

  // Wait mode is not an input here: counting continues through it
  assign running = !stop_mode_i && !hv_block && !dis_cfg
                   && (state_r == ST_COUNT);

  assign pre_clear = stop_instr_i || por_clear || vector_fetch_i;

  // Prescaler and timeout counter
  logic [PRE_W-1:0] pre_r;
  logic [CNT_W-1:0] cnt_r;
  logic             wrap;
  logic             expire;

  // Short rate taps prescaler bit 7; long rate uses the full 12 bits
  assign wrap = rate_long ? (&pre_r) : (&pre_r[SHORT_TAP-1:0]);

  // Overflow lands 16 cycles early, the part of the prescaler a service keeps
  assign expire = running && (rate_long ? ({cnt_r, pre_r} == LONG_END)
                                        : ({cnt_r, pre_r[SHORT_TAP-1:0]} == SHORT_END));

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      pre_r <= '0;
    end else if (internal_reset_i) begin
      pre_r <= '0;
    end else if (pre_clear || expire) begin
      pre_r <= '0;
    end else if (service) begin
      pre_r[PRE_W-1:SVC_LO_BIT] <= '0;
    end else if (running) begin
      pre_r <= pre_r + 12'h001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      cnt_r <= '0;
    end else if (internal_reset_i || service || expire) begin
      cnt_r <= '0;
    end else if (running && wrap) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  // Reset pin pull
  logic [5:0] pull_cnt_r;

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r    <= ST_COUNT;
      pull_cnt_r <= '0;
    end else begin
      case (state_r)
        ST_COUNT: begin
          pull_cnt_r <= '0;
          if (expire) begin
            state_r <= ST_PULL;
          end
        end
        ST_PULL: begin
          pull_cnt_r <= pull_cnt_r + 6'h01;
          if (pull_cnt_r == PULL_LAST) begin
            state_r <= ST_COUNT;
          end
        end
        default: begin
          state_r <= ST_COUNT;
        end
      endcase
    end
  end

  // Pin only ever driven low; released pin floats to its pull-up
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      reset_pin_oe_n_o <= 1'b1;
      timeout_reset_o  <= 1'b0;
    end else begin
      reset_pin_oe_n_o <= !(expire || (state_r == ST_PULL && pull_cnt_r != PULL_LAST));
      timeout_reset_o  <= expire || (state_r == ST_PULL && pull_cnt_r != PULL_LAST);
    end
  end

  assign reset_pin_o = 1'b0;

  // Sticky status, write one to clear; a new event beats the clear
  logic [ST_W-1:0] st_r;
  logic [ST_W-1:0] msk_r;
  logic [ST_W-1:0] ev;
  logic            hv_block_d_r;

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      hv_block_d_r <= 1'b0;
    end else begin
      hv_block_d_r <= hv_block;
    end
  end

  always_comb begin
    ev               = '0;
    ev[ST_CAUSE_BIT] = expire;
    ev[ST_HVBLK_BIT] = hv_block && !hv_block_d_r;
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= (st_r & ~((wr_en && hit_st) ? pwdata_i[ST_W-1:0] : '0)) | ev;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      msk_r <= MASK_RESET;
    end else if (wr_en && hit_msk) begin
      msk_r <= pwdata_i[ST_W-1:0];
    end
  end

  // Summary line to the system controller, never a processor request
  assign irq_o                 = |(st_r & msk_r);
  assign watchdog_cause_flag_o = st_r[ST_CAUSE_BIT];

  // Read data
  logic [31:0] rd_nxt;

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_svc) begin
      rd_nxt[7:0] = reset_vector_low_i;
    end else if (hit_ctl) begin
      rd_nxt[1:0] = ctl_r;
    end else if (hit_st) begin
      rd_nxt[1:0] = st_r;
      rd_nxt[8]   = rst_pin_s;
      rd_nxt[9]   = hv_block;
    end else if (hit_msk) begin
      rd_nxt[1:0] = msk_r;
    end else if (hit_cnt) begin
      rd_nxt[17:0] = {cnt_r, pre_r};
    end
  end

  // Read data are flopped in the setup cycle, valid in the access phase
  always_ff @(posedge sys_clk_i or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= rd_nxt;
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule : runaway_code_watchdog
`default_nettype wire

/* verilog/wdog_pkg.sv */
// Constants for the runaway code watchdog
package wdog_pkg;

  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_SERVICE  = 16'hffff;
  localparam logic [15:0] IDX_CONTROL  = 16'h0000;
  localparam logic [15:0] IDX_STATUS   = 16'h0001;
  localparam logic [15:0] IDX_MASK     = 16'h0002;
  localparam logic [15:0] IDX_COUNT    = 16'h0003;
  localparam int          ADDR_W       = 18;

  // Control register fields
  localparam int          CTL_RATE_BIT = 0;
  localparam int          CTL_DIS_BIT  = 1;
  localparam logic [1:0]  CTL_RESET    = 2'h0;

  // Status and mask fields
  localparam int          ST_W         = 2;
  localparam int          ST_CAUSE_BIT = 0;
  localparam int          ST_HVBLK_BIT = 1;
  localparam logic [1:0]  ST_RESET     = 2'h0;
  localparam logic [1:0]  MASK_RESET   = 2'h0;

  // Counter geometry
  localparam int          PRE_W        = 12;
  localparam int          CNT_W        = 6;
  localparam int          SVC_LO_BIT   = 4;
  localparam int          SHORT_TAP    = 7;
  localparam int          RESIDUE_CYC  = 16;

  // Timing, in oscillator clock cycles (one per sys_clk)
  localparam int          CLK_MHZ      = 200;
  localparam int          PULL_CYC     = 32;
  localparam int          POR_CYC      = 4096;
  localparam int          SHORT_CYC    = (1 << 13) - RESIDUE_CYC;
  localparam int          LONG_CYC     = (1 << 18) - RESIDUE_CYC;

endpackage : wdog_pkg

/* verilog/wdog_sync.sv */
// Two flip-flop synchroniser for pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module wdog_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  // Data
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end

endmodule : wdog_sync
`default_nettype wire
